// ---- design/usb_routing_defs.svh ----
// Purpose: Constants for the three-port USB routing block
// Assumes: 40 MHz system clock
// Notes:   Included by the package and the power and routing design files
`ifndef USB_ROUTING_DEFS_SVH
`define USB_ROUTING_DEFS_SVH

`define PORT_COUNT            3
`define PORT_OTG              0
`define PORT_HOST1            1
`define PORT_HOST2            2
`define SER_WIDTH             6
`define SYS_CLK_HZ            40000000
`define LP_CLK_HZ             32768
`define LP_DIV_COUNT          ((`SYS_CLK_HZ) / (`LP_CLK_HZ))
`define LP_CNT_WIDTH          11
`define IDLE_LP_TICKS         4'h8
`define IF_MODE_SERIAL        2'h0
`define IF_MODE_ULPI          2'h1
`define IF_MODE_LINK          2'h2
`define LINE_TX_DP            0
`define LINE_TX_DM            1
`define LINE_TX_OE            2
`define LINE_RX_DP            3
`define LINE_RX_DM            4
`define LINE_RX_RCV           5
`define LINE_J                6'h28
`define BYPASS_RESET          1'b0

`endif

// ---- design/usb_routing_pkg.sv ----
// Purpose: Types for the three-port USB routing block
// Assumes: Constants come from usb_routing_defs.svh
// Notes:   Power states Gray coded along the usual path
`default_nettype none
`include "usb_routing_defs.svh"
package usb_routing_pkg;
  typedef logic [1:0] if_mode_t;
  typedef enum logic [1:0] {
    PWR_RUN     = 2'h0,
    PWR_IDLE    = 2'h1,
    PWR_SUSPEND = 2'h3,
    PWR_GATED   = 2'h2
  } pwr_state_e;
endpackage
`default_nettype wire

// ---- design/usb_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_sys_in
// Notes:   Stage one feeds only stage two
`default_nettype none
module usb_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, val_q;
  logic [WIDTH-1:0] val_d;

  always_comb begin
    val_d = val_q;
    if (s2_q == s3_q) begin
      val_d = s3_q;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      val_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      val_q <= val_d;
    end
  end

  assign sync_out = val_q;
endmodule
`default_nettype wire

// ---- design/usb_power_ctrl.sv ----
// Purpose: Per-core low-power unit stepped by a 32 kHz enable
// Assumes: lp_tick_in is a one-cycle pulse from the divider
// Notes:   Wake detection runs while core clocks are gated
`default_nettype none
`include "usb_routing_defs.svh"
module usb_power_ctrl
  import usb_routing_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic lp_tick_in,
  // Core and line status
  input  wire logic suspend_req_in,
  input  wire logic bus_idle_in,
  input  wire logic line_activity_in,
  // Outputs
  output logic      xcvr_suspend_out,
  output logic      clk_gate_out,
  output logic      wakeup_out
);
  pwr_state_e state_q, state_d;
  logic [3:0] idle_cnt_q, idle_cnt_d;
  logic       wake_q, wake_d;

  always_comb begin
    state_d    = state_q;
    idle_cnt_d = idle_cnt_q;
    wake_d     = 1'b0;
    unique case (state_q)
      PWR_RUN: begin
        idle_cnt_d = 4'h0;
        if (suspend_req_in && bus_idle_in) begin
          state_d = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (!bus_idle_in || !suspend_req_in) begin
          state_d = PWR_RUN;
        end else if (lp_tick_in) begin
          idle_cnt_d = idle_cnt_q + 4'h1;
          if (idle_cnt_q == `IDLE_LP_TICKS - 4'h1) begin
            state_d = PWR_SUSPEND;
          end
        end
      end
      PWR_SUSPEND: begin
        if (line_activity_in) begin
          state_d = PWR_RUN;
          wake_d  = 1'b1;
        end else if (lp_tick_in) begin
          state_d = PWR_GATED; // RL17
        end
      end
      PWR_GATED: begin
        if (lp_tick_in && line_activity_in) begin // RL18
          state_d = PWR_RUN;
          wake_d  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_q    <= PWR_RUN;
      idle_cnt_q <= 4'h0;
      wake_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      idle_cnt_q <= idle_cnt_d;
      wake_q     <= wake_d;
    end
  end

  assign xcvr_suspend_out = (state_q == PWR_SUSPEND) || (state_q == PWR_GATED);
  assign clk_gate_out     = (state_q == PWR_GATED);
  assign wakeup_out       = wake_q;
endmodule
`default_nettype wire

// ---- design/usb_three_port_routing.sv ----
// Purpose: Port routing, interface modes and low power of three USB ports
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes:   Serial port lines: bit0 tx_dp, 1 tx_dm, 2 tx_oe, 3 rx_dp, 4 rx_dm, 5 rx_rcv
//          Link mode drives one emulated line; isolated cores see J
//
// How it works
// RL1: Three cores, each owning one port
// RL2: Without bypass each core drives its port
// RL3: High-speed or full/low-speed per port
// RL4: Link mode emulates back-to-back transceivers
// RL5: Link mode only host 1/2, full/low-speed
// RL6: Host 1 core: host, full/low-speed only
// RL7: Host 2 core: host, all three speeds
// RL8: Host 2 takes ULPI or serial transceiver
// RL9: OTG port always has external transceiver
// RL10: Serial transceiver holds own OTG registers
// RL11: ULPI transceiver attached for high-speed
// RL12: Bypass bit enables bypass routing
// RL13: Bypass only with OTG serial, host1 link
// RL14: Bypass routes OTG port to host 1
// RL15: Bypass isolates OTG and host 1 cores
// RL16: Per-core power unit on 32 kHz clock
// RL17: Idle and suspended lets core clocks stop
// RL18: Low-power clock keeps running for wake-up
// RL19: Peripheral bus and DMA master ports; this block has neither, control arrives as plain input ports
// RL20: Bypass bit clears at reset
`default_nettype none
`include "usb_routing_defs.svh"
module usb_three_port_routing
  import usb_routing_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  // Control, arriving as plain input ports from outside this block
  input  wire logic                   bypass_req_in, // RL19
  input  wire logic [1:0]             otg_mode_in,
  input  wire logic [1:0]             host1_mode_in,
  input  wire logic [1:0]             host2_mode_in,
  input  wire logic [2:0]             hs_enable_in,
  input  wire logic [2:0]             suspend_req_in,
  // Core-side serial lines
  input  wire logic [`SER_WIDTH-1:0]  otg_core_in,
  input  wire logic [`SER_WIDTH-1:0]  host1_core_in,
  input  wire logic [`SER_WIDTH-1:0]  host2_core_in,
  output logic      [`SER_WIDTH-1:0]  otg_core_out,
  output logic      [`SER_WIDTH-1:0]  host1_core_out,
  output logic      [`SER_WIDTH-1:0]  host2_core_out,
  // Pin-side serial lines
  input  wire logic [`SER_WIDTH-1:0]  otg_pin_in,
  input  wire logic [`SER_WIDTH-1:0]  host1_pin_in,
  input  wire logic [`SER_WIDTH-1:0]  host2_pin_in,
  output logic      [`SER_WIDTH-1:0]  otg_pin_out,
  output logic      [`SER_WIDTH-1:0]  host1_pin_out,
  output logic      [`SER_WIDTH-1:0]  host2_pin_out,
  // Status
  output logic                        bypass_active_out,
  output logic                        config_error_out,
  output logic      [2:0]             hs_active_out,
  output logic      [2:0]             xcvr_suspend_out,
  output logic      [2:0]             clk_gate_out,
  output logic      [2:0]             wakeup_out
);
  localparam int SW = `SER_WIDTH;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SW-1:0] pin_raw [3];
  logic [SW-1:0] pin_s   [3];
  logic [SW-1:0] otg_pin_s, host1_pin_s, host2_pin_s;

  assign pin_raw[`PORT_OTG]   = otg_pin_in;
  assign pin_raw[`PORT_HOST1] = host1_pin_in;
  assign pin_raw[`PORT_HOST2] = host2_pin_in;

  genvar p;
  generate
    for (p = 0; p < `PORT_COUNT; p++) begin : g_sync
      usb_pin_sync #(.WIDTH(SW)) u_sync (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (pin_raw[p]),
        .sync_out   (pin_s[p])
      );
    end
  endgenerate

  assign otg_pin_s   = pin_s[`PORT_OTG];
  assign host1_pin_s = pin_s[`PORT_HOST1];
  assign host2_pin_s = pin_s[`PORT_HOST2];

  ////////////////////////////////////////////////////////////////////////////
  // Mode checks and bypass gating
  if_mode_t mode_otg, mode_h1, mode_h2;
  logic     bypass_ok;
  logic     cfg_err_d, cfg_err_q;
  logic     bypass_d, bypass_q;
  logic [2:0] hs_d, hs_q;

  always_comb begin
    mode_otg  = `IF_MODE_SERIAL;                 // RL9
    mode_h1   = (host1_mode_in == `IF_MODE_LINK) ? `IF_MODE_LINK
                                                 : `IF_MODE_SERIAL; // RL5
    mode_h2   = host2_mode_in;                    // RL8
    cfg_err_d = (otg_mode_in != `IF_MODE_SERIAL)
             || (host1_mode_in == `IF_MODE_ULPI);
    if (host2_mode_in == 2'h3) begin
      mode_h2   = `IF_MODE_SERIAL;
      cfg_err_d = 1'b1;
    end
    bypass_ok = (mode_otg == `IF_MODE_SERIAL) && (mode_h1 == `IF_MODE_LINK); // RL13
    if (bypass_req_in && !bypass_ok) begin
      cfg_err_d = 1'b1;
    end
    bypass_d  = bypass_req_in && bypass_ok;      // RL12
    hs_d[`PORT_OTG]   = hs_enable_in[`PORT_OTG];  // RL3
    hs_d[`PORT_HOST1] = 1'b0;                     // RL6
    hs_d[`PORT_HOST2] = hs_enable_in[`PORT_HOST2]
                     && (mode_h2 == `IF_MODE_ULPI); // RL7
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing
  logic [SW-1:0] otg_core_d, h1_core_d, h2_core_d;
  logic [SW-1:0] otg_pin_d, h1_pin_d, h2_pin_d;
  logic [SW-1:0] otg_core_q, h1_core_q, h2_core_q;
  logic [SW-1:0] otg_pin_q, h1_pin_q, h2_pin_q;
  logic [SW-1:0] h1_link, h2_link;

  // Link mode: one emulated line, seen by core and peer alike.
  // Core wins if both drive; with neither, the pull-up gives J.
  function automatic logic [SW-1:0] link_line(input logic [SW-1:0] core_tx,
                                              input logic [SW-1:0] peer_tx);
    logic          dp;
    logic          dm;
    logic [SW-1:0] r;
    dp = 1'b1;
    dm = 1'b0;
    if (core_tx[`LINE_TX_OE]) begin
      dp = core_tx[`LINE_TX_DP];
      dm = core_tx[`LINE_TX_DM];
    end else if (peer_tx[`LINE_TX_OE]) begin
      dp = peer_tx[`LINE_TX_DP];
      dm = peer_tx[`LINE_TX_DM];
    end
    r               = '0;
    r[`LINE_RX_DP]  = dp;
    r[`LINE_RX_DM]  = dm;
    r[`LINE_RX_RCV] = dp;
    return r;
  endfunction

  assign h1_link = link_line(host1_core_in, host1_pin_s);
  assign h2_link = link_line(host2_core_in, host2_pin_s);

  always_comb begin
    otg_core_d = otg_pin_s;                       // RL2
    otg_pin_d  = otg_core_in;
    h1_core_d  = host1_pin_s;
    h1_pin_d   = host1_core_in;
    h2_core_d  = host2_pin_s;                     // RL1
    h2_pin_d   = host2_core_in;
    if (mode_h1 == `IF_MODE_LINK) begin
      h1_core_d = h1_link;                        // RL4
      h1_pin_d  = h1_link;
    end
    if (mode_h2 == `IF_MODE_LINK) begin
      h2_core_d = h2_link;                        // RL5
      h2_pin_d  = h2_link;
    end
    if (bypass_q) begin
      otg_pin_d  = host1_pin_s;                   // RL14
      h1_pin_d   = otg_pin_s;
      otg_core_d = `LINE_J;                       // RL15
      h1_core_d  = `LINE_J;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bypass_q   <= `BYPASS_RESET;                // RL20
      cfg_err_q  <= 1'b0;
      hs_q       <= 3'h0;
      otg_core_q <= '0;
      h1_core_q  <= '0;
      h2_core_q  <= '0;
      otg_pin_q  <= '0;
      h1_pin_q   <= '0;
      h2_pin_q   <= '0;
    end else begin
      bypass_q   <= bypass_d;
      cfg_err_q  <= cfg_err_d;
      hs_q       <= hs_d;
      otg_core_q <= otg_core_d;
      h1_core_q  <= h1_core_d;
      h2_core_q  <= h2_core_d;
      otg_pin_q  <= otg_pin_d;
      h1_pin_q   <= h1_pin_d;
      h2_pin_q   <= h2_pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power clock enable
  logic [`LP_CNT_WIDTH-1:0] lp_cnt_q, lp_cnt_d;
  logic                     lp_tick_q, lp_tick_d;

  always_comb begin
    lp_tick_d = 1'b0;
    lp_cnt_d  = lp_cnt_q + 1'b1;
    if (lp_cnt_q == `LP_CNT_WIDTH'(`LP_DIV_COUNT - 1)) begin
      lp_cnt_d  = '0;
      lp_tick_d = 1'b1;                           // RL18
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      lp_cnt_q  <= '0;
      lp_tick_q <= 1'b0;
    end else begin
      lp_cnt_q  <= lp_cnt_d;
      lp_tick_q <= lp_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-core power units
  logic [SW-1:0] line_rx [3];
  logic [2:0]    sus_w, gate_w, wake_w, idle_w, act_w;
  logic [2:0]    sus_q, gate_q, wake_q;

  assign line_rx[0] = otg_pin_s;
  // Link ports judge idle from the emulated line, not the raw pins
  assign line_rx[1] = (mode_h1 == `IF_MODE_LINK) ? h1_link : host1_pin_s;
  assign line_rx[2] = (mode_h2 == `IF_MODE_LINK) ? h2_link : host2_pin_s;

  genvar g;
  generate
    for (g = 0; g < `PORT_COUNT; g++) begin : g_pwr
      assign idle_w[g] = line_rx[g][`LINE_RX_DP] && !line_rx[g][`LINE_RX_DM];
      assign act_w[g]  = !idle_w[g];
      usb_power_ctrl u_pwr (                      // RL16
        .clk_sys_in       (clk_sys_in),
        .sys_rst_in       (sys_rst_in),
        .lp_tick_in       (lp_tick_q),
        .suspend_req_in   (suspend_req_in[g]),
        .bus_idle_in      (idle_w[g]),
        .line_activity_in (act_w[g]),
        .xcvr_suspend_out (sus_w[g]),
        .clk_gate_out     (gate_w[g]),
        .wakeup_out       (wake_w[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sus_q  <= 3'h0;
      gate_q <= 3'h0;
      wake_q <= 3'h0;
    end else begin
      sus_q  <= sus_w;
      gate_q <= gate_w;                           // RL17
      wake_q <= wake_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign otg_core_out      = otg_core_q;
  assign host1_core_out    = h1_core_q;
  assign host2_core_out    = h2_core_q;
  assign otg_pin_out       = otg_pin_q;
  assign host1_pin_out     = h1_pin_q;
  assign host2_pin_out     = h2_pin_q;
  assign bypass_active_out = bypass_q;
  assign config_error_out  = cfg_err_q;
  assign hs_active_out     = hs_q;
  assign xcvr_suspend_out  = sus_q;
  assign clk_gate_out      = gate_q;
  assign wakeup_out        = wake_q;
endmodule
`default_nettype wire

// ---- test/usb_three_port_routing_checker.sv ----
// Purpose: Port assertions for usb_three_port_routing
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
`default_nettype none
`include "usb_routing_defs.svh"
module usb_three_port_routing_checker (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  // Control
  input wire logic       bypass_req_in,
  input wire logic [1:0] otg_mode_in,
  input wire logic [1:0] host1_mode_in,
  input wire logic [1:0] host2_mode_in,
  input wire logic [2:0] hs_enable_in,
  input wire logic [5:0] otg_core_in,
  input wire logic [5:0] host2_core_in,
  // Observed outputs
  input wire logic [5:0] otg_core_out,
  input wire logic [5:0] host1_core_out,
  input wire logic [5:0] otg_pin_out,
  input wire logic [5:0] host2_pin_out,
  input wire logic       bypass_active_out,
  input wire logic       config_error_out,
  input wire logic [2:0] hs_active_out,
  input wire logic [2:0] xcvr_suspend_out,
  input wire logic [2:0] clk_gate_out,
  input wire logic [2:0] wakeup_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  chk_bypass_grant: assert property (!$past(sys_rst_in) |-> bypass_active_out ==
    $past(bypass_req_in && host1_mode_in == `IF_MODE_LINK)) else $error("bypass grant");
  chk_core_isolate: assert property (bypass_active_out && $past(bypass_active_out) |->
    otg_core_out == `LINE_J && host1_core_out == `LINE_J) else $error("core not isolated");
  chk_cfg_error: assert property (!$past(sys_rst_in) |-> config_error_out ==
    $past(otg_mode_in != `IF_MODE_SERIAL || host1_mode_in == `IF_MODE_ULPI ||
    host2_mode_in == 2'h3 || (bypass_req_in && host1_mode_in != `IF_MODE_LINK)))
    else $error("config error flag");
  chk_host1_no_hs: assert property (hs_active_out[1] == 1'b0) else $error("host1 high speed");
  chk_host2_hs: assert property (!$past(sys_rst_in) |-> hs_active_out[2] ==
    $past(hs_enable_in[2] && host2_mode_in == `IF_MODE_ULPI)) else $error("host2 speed");
  chk_otg_tx_path: assert property (!$past(sys_rst_in) && !$past(bypass_active_out) |->
    otg_pin_out[2:0] == $past(otg_core_in[2:0])) else $error("otg tx path");
  chk_h2_tx_path: assert property ($past(host2_mode_in) == `IF_MODE_SERIAL &&
    !$past(sys_rst_in) |-> host2_pin_out[2:0] == $past(host2_core_in[2:0]))
    else $error("host2 tx path");
  chk_gate_after_susp: assert property ($rose(clk_gate_out[0]) |->
    $past(xcvr_suspend_out[0])) else $error("gate before suspend");
  chk_wake_pulse: assert property (wakeup_out[0] |=> !wakeup_out[0])
    else $error("wake pulse too long");

  cov_bypass: cover property (bypass_active_out);
  cov_gate: cover property (clk_gate_out[0]);
  cov_wake: cover property (wakeup_out[0]);
  cov_hs: cover property (hs_active_out[2]);
endmodule

bind usb_three_port_routing usb_three_port_routing_checker usb_three_port_routing_checker_i (
  .clk_sys_in, .sys_rst_in, .bypass_req_in, .otg_mode_in, .host1_mode_in, .host2_mode_in,
  .hs_enable_in, .otg_core_in, .host2_core_in, .otg_core_out, .host1_core_out,
  .otg_pin_out, .host2_pin_out, .bypass_active_out, .config_error_out, .hs_active_out,
  .xcvr_suspend_out, .clk_gate_out, .wakeup_out);
`default_nettype wire

// ---- test/usb_far_xcvr.sv ----
// Purpose: External transceivers or link peers on the three ports
// Assumes: Pull-up idle gives J (rcv=1, dp=1, dm=0)
// Notes:   slow_in adds one cycle of lag per port
`default_nettype none
module usb_far_xcvr (
  input  wire logic        clk_sys_in,
  input  wire logic [2:0]  send_in,
  input  wire logic [2:0]  slow_in,
  input  wire logic [5:0]  sym_in,
  output logic      [17:0] rx_out
);
  logic [17:0] now_w;
  logic [17:0] lag_q;
  // Released line falls back to J
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      now_w[p*6+:6] = send_in[p] ? sym_in : 6'h28;
      rx_out[p*6+:6] = slow_in[p] ? lag_q[p*6+:6] : now_w[p*6+:6];
    end
  end
  always_ff @(posedge clk_sys_in) begin
    lag_q <= now_w;
  end
endmodule
`default_nettype wire

// ---- test/usb_three_port_routing_bench.sv ----
// Purpose: Self-checking bench for usb_three_port_routing
// Assumes: 40 MHz clock, inputs driven on falling edge
// Notes:   Far side modelled by usb_far_xcvr
`default_nettype none
`include "usb_routing_defs.svh"
module usb_three_port_routing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = `LP_DIV_COUNT;
  localparam int NI = `IDLE_LP_TICKS;
  logic       clk_sys_in, sys_rst_in, bypass_req_in;
  logic [1:0] otg_mode_in, host1_mode_in, host2_mode_in;
  logic [2:0] hs_enable_in, suspend_req_in, send, slow;
  logic [5:0] otg_core_in, host1_core_in, host2_core_in, sym;
  logic [5:0] otg_core_out, host1_core_out, host2_core_out;
  logic [5:0] otg_pin_in, host1_pin_in, host2_pin_in;
  logic [5:0] otg_pin_out, host1_pin_out, host2_pin_out;
  logic       bypass_active_out, config_error_out;
  logic [2:0] hs_active_out, xcvr_suspend_out, clk_gate_out, wakeup_out;
  int         fail_count = 0;
  int         n_checks = 0;
  int         cyc = 0;

  usb_three_port_routing usb_three_port_routing_i (.clk_sys_in, .sys_rst_in,
    .bypass_req_in, .otg_mode_in, .host1_mode_in, .host2_mode_in, .hs_enable_in,
    .suspend_req_in, .otg_core_in, .host1_core_in, .host2_core_in, .otg_core_out,
    .host1_core_out, .host2_core_out, .otg_pin_in, .host1_pin_in, .host2_pin_in,
    .otg_pin_out, .host1_pin_out, .host2_pin_out, .bypass_active_out,
    .config_error_out, .hs_active_out, .xcvr_suspend_out, .clk_gate_out, .wakeup_out);
  usb_far_xcvr usb_far_xcvr_i (.clk_sys_in, .send_in(send), .slow_in(slow),
    .sym_in(sym), .rx_out({host2_pin_in, host1_pin_in, otg_pin_in}));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    tick(1);
    chk("status", 6'h00, {1'b0, bypass_active_out, config_error_out, hs_active_out});
    chk("power", 6'h00, {xcvr_suspend_out, clk_gate_out});
  endtask
  task automatic t_tx();
    for (int i = 0; i < 2; i++) begin
      otg_core_in = i ? 6'h06 : 6'h05;
      host1_core_in = otg_core_in;
      host2_core_in = otg_core_in;
      tick(2);
      chk("otg_tx", {3'h0, otg_core_in[2:0]}, {3'h0, otg_pin_out[2:0]});
      chk("h1_tx", {3'h0, otg_core_in[2:0]}, {3'h0, host1_pin_out[2:0]});
      chk("h2_tx", {3'h0, otg_core_in[2:0]}, {3'h0, host2_pin_out[2:0]});
    end
    {otg_core_in, host1_core_in, host2_core_in} = 18'h00000;
  endtask
  task automatic t_rx();
    sym = 6'h10;
    slow = 3'b100;
    send = 3'b100;
    tick(8);
    chk("h2_rx", 6'h10, {host2_core_out[5:3], 3'h0});
    chk("otg_rx", 6'h28, {otg_core_out[5:3], 3'h0});
    send = 3'b000;
  endtask
  task automatic t_modes();
    hs_enable_in = 3'b111;
    for (int m = 0; m < 4; m++) begin
      host2_mode_in = 2'(m);
      tick(2);
      chk("h2_mode", {2'h0, m == 1, 1'b0, 1'b1, m == 3},
        {2'h0, hs_active_out, config_error_out});
    end
    host2_mode_in = 2'h0;
    for (int m = 0; m < 4; m++) begin
      otg_mode_in = 2'(m);
      tick(2);
      chk("otg_mode", {5'h0, m != 0}, {5'h0, config_error_out});
    end
    otg_mode_in = 2'h0;
    host1_mode_in = `IF_MODE_ULPI;
    tick(2);
    chk("h1_ulpi", 6'h01, {4'h0, hs_active_out[1], config_error_out});
    host1_mode_in = 2'h0;
    hs_enable_in = 3'b000;
  endtask
  task automatic t_link();
    hs_enable_in = 3'b100;
    host1_mode_in = `IF_MODE_LINK;
    host2_mode_in = `IF_MODE_LINK;
    host1_core_in = 6'h06;
    host2_core_in = 6'h06;
    tick(2);
    chk("h1_link_core", 6'h10, host1_core_out);
    chk("h1_link_pin", 6'h10, host1_pin_out);
    chk("h2_link_core", 6'h10, host2_core_out);
    {host1_core_in, host2_core_in} = 12'h000;
    sym = 6'h06;
    send = 3'b110;
    tick(8);
    chk("h1_link_peer", 6'h10, host1_core_out);
    chk("h2_link_peer", 6'h10, host2_pin_out);
    send = 3'b000;
    tick(8);
    chk("h1_link_idle", `LINE_J, host1_core_out);
    chk("h2_link_hs", 6'h00, {4'h0, hs_active_out[2], config_error_out});
    {host1_mode_in, host2_mode_in} = 4'h0;
    hs_enable_in = 3'b000;
  endtask
  task automatic t_bypass();
    bypass_req_in = 1'b1;
    tick(2);
    chk("bp_refused", 6'h01, {4'h0, bypass_active_out, config_error_out});
    host1_mode_in = `IF_MODE_LINK;
    sym = 6'h10;
    send = 3'b010;
    tick(8);
    chk("bp_on", 6'h02, {4'h0, bypass_active_out, config_error_out});
    chk("otg_iso", `LINE_J, otg_core_out);
    chk("h1_iso", `LINE_J, host1_core_out);
    chk("otg_route", 6'h10, otg_pin_out);
    chk("h1_route", 6'h28, host1_pin_out);
    {bypass_req_in, host1_mode_in, send} = 6'h00;
    tick(8);
    chk("bp_off", 6'h00, {5'h0, bypass_active_out});
  endtask
  task automatic t_power();
    int n;
    suspend_req_in = 3'b001;
    n = 0;
    while (xcvr_suspend_out[0] !== 1'b1 && n < (NI + 2) * TK) begin
      tick(1);
      n++;
    end
    chk("susp_time", 6'h01, {5'h0, n >= (NI - 1) * TK && n <= NI * TK + 8});
    n = 0;
    while (clk_gate_out[0] !== 1'b1 && n < 2 * TK) begin
      tick(1);
      n++;
    end
    chk("gate", 6'h01, {5'h0, clk_gate_out[0]});
    send = 3'b001;
    slow = 3'b001;
    n = 0;
    while (wakeup_out[0] !== 1'b1 && n < 2 * TK) begin
      tick(1);
      n++;
    end
    chk("wake", 6'h01, {5'h0, wakeup_out[0]});
    tick(1);
    chk("wake_end", 6'h00, {5'h0, wakeup_out[0]});
    {suspend_req_in, send} = 6'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    sys_rst_in = 1'b1;
    {bypass_req_in, otg_mode_in, host1_mode_in, host2_mode_in} = 7'h00;
    {hs_enable_in, suspend_req_in, send, slow} = 12'h000;
    {otg_core_in, host1_core_in, host2_core_in, sym} = 24'h000000;
    tick(10);
    sys_rst_in = 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_modes();
    t_link();
    t_bypass();
    t_power();
    final_report();
  end
endmodule
`default_nettype wire
